// ### rtl/bcgoc_top.sv
// Per-block clock gating, ring oscillator run control and wake handling
`include "bcgoc_params.svh"

module bcgoc_top #(
   parameter int                NBLK         = 32,
   parameter int                NSRC         = 8,
   parameter logic [NSRC*8-1:0] WAKE_LEN_VEC = {NSRC{`BCGOC_WAKE_LEN_DEF}}
) (
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 rst,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Peripheral blocks
   input  wire logic [NBLK-1:0]      block_idle,
   output logic      [NBLK-1:0]      block_sleep_request,
   output logic      [NBLK-1:0]      block_clock_request,
   output logic      [NBLK-1:0]      block_clock_gate_en,
   output logic      [NBLK-1:0]      block_reset,
   // Processor
   input  wire logic                 cpu_sleep_enter,
   output logic                      cpu_clock_off,
   output logic                      cpu_irq,
   // Wake sources from pins
   input  wire logic [NSRC-1:0]      wake_source,
   output logic                      wake_active,
   // Oscillator
   output bcgoc_pkg::bcgoc_osc_s     osc_ctl
);

   // ==========================================================
   // Registers
   logic [1:0]              mode_ff;
   logic                    sleep_flag_ff;
   logic [NBLK-1:0]         sleep_en_ff;
   logic [NBLK-1:0]         blk_en_ff;
   logic [NSRC-1:0]         group_irq_enable_ff;
   logic [NSRC-1:0]         wake_edge_ff;
   logic [31:0]             prdata_ff;
   logic                    pslverr_ff;
   logic                    cpu_clock_off_ff;
   logic                    cpu_irq_ff;
   bcgoc_pkg::bcgoc_state_e st_ff      [NBLK];
   bcgoc_pkg::bcgoc_state_e nxt_st     [NBLK];
   logic [NBLK-1:0]         gate_en_ff;
   logic [NSRC-1:0]         sync1_ff;
   logic [NSRC-1:0]         sync2_ff;
   logic [NSRC-1:0]         sync3_ff;
   logic [NSRC-1:0]         src_ff;
   logic [7:0]              wake_cnt_ff [NSRC];
   logic [NSRC-1:0]         wake_trig;
   logic [NSRC-1:0]         level_irq;
   logic [NBLK-1:0]         sleeping;
   logic [NBLK-1:0]         clk_req;
   logic                    wr_en;
   logic                    setup;
   logic                    mapped;
   logic                    allowed;
   logic                    run_calc;
   logic                    wake_any;

   // ==========================================================
   // Helpers
   function automatic logic clk_needed(input bcgoc_pkg::bcgoc_state_e s);
      clk_needed = (s == bcgoc_pkg::BCGOC_FULL) || (s == bcgoc_pkg::BCGOC_PREP);
   endfunction : clk_needed

   function automatic logic is_reg(input logic [7:0] a);
      is_reg = (a == `BCGOC_OFS_CLK_CTRL) || (a == `BCGOC_OFS_SLEEP_EN)
            || (a == `BCGOC_OFS_BLK_EN) || (a == `BCGOC_OFS_CLK_REQ)
            || (a == `BCGOC_OFS_OSC_STAT) || (a == `BCGOC_OFS_WAKE_EN)
            || (a == `BCGOC_OFS_WAKE_EDGE);
   endfunction : is_reg

   // ==========================================================
   // APB decode
   assign setup   = psel && !penable;
   assign mapped  = is_reg(paddr);
   assign wr_en   = psel && penable && pwrite && mapped;
   assign pready  = 1'b1;
   assign prdata  = prdata_ff;
   assign pslverr = pslverr_ff;

   // Global sleep flag and mode; a wake beats a same-cycle write of the flag, not of the mode
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         mode_ff       <= `BCGOC_MODE_RST;
         sleep_flag_ff <= 1'b0;
      end
      else
      begin
         if (wr_en && paddr == `BCGOC_OFS_CLK_CTRL)
         begin
            mode_ff       <= pwdata[`BCGOC_MODE_MSB:`BCGOC_MODE_LSB];
            sleep_flag_ff <= pwdata[`BCGOC_SLEEP_FLAG_BIT];
         end
         if (|wake_trig)
         begin
            sleep_flag_ff <= 1'b0;
         end
      end
   end

   // Block enables of sleeping blocks hold: their bus clocks are gated; sleep enables stay writable
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sleep_en_ff <= '0;
         blk_en_ff   <= '0;
      end
      else
      begin
         if (wr_en && paddr == `BCGOC_OFS_SLEEP_EN)
         begin
            sleep_en_ff <= pwdata[NBLK-1:0];
         end
         if (wr_en && paddr == `BCGOC_OFS_BLK_EN)
         begin
            blk_en_ff <= (pwdata[NBLK-1:0] & ~sleeping) | (blk_en_ff & sleeping);
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         group_irq_enable_ff <= '0;
         wake_edge_ff        <= '1;
      end
      else
      begin
         if (wr_en && paddr == `BCGOC_OFS_WAKE_EN)
         begin
            group_irq_enable_ff <= pwdata[NSRC-1:0];
         end
         if (wr_en && paddr == `BCGOC_OFS_WAKE_EDGE)
         begin
            wake_edge_ff <= pwdata[NSRC-1:0];
         end
      end
   end

   // Read data is latched in setup so the access phase sees a flop
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         prdata_ff  <= '0;
         pslverr_ff <= 1'b0;
      end
      else if (setup)
      begin
         pslverr_ff <= !mapped;
         prdata_ff  <= '0;
         unique case (paddr)
            `BCGOC_OFS_CLK_CTRL:
            begin
               prdata_ff[`BCGOC_MODE_MSB:`BCGOC_MODE_LSB] <= mode_ff;
               prdata_ff[`BCGOC_SLEEP_FLAG_BIT]           <= sleep_flag_ff;
            end
            `BCGOC_OFS_SLEEP_EN:  prdata_ff[NBLK-1:0] <= sleep_en_ff;
            `BCGOC_OFS_BLK_EN:    prdata_ff[NBLK-1:0] <= blk_en_ff;
            `BCGOC_OFS_CLK_REQ:   prdata_ff[NBLK-1:0] <= clk_req;
            `BCGOC_OFS_OSC_STAT:
            begin
               prdata_ff[`BCGOC_STAT_RUN_BIT]    <= osc_ctl.osc_run_enable;
               prdata_ff[`BCGOC_STAT_ALLOW_BIT]  <= allowed;
               prdata_ff[`BCGOC_STAT_CPUOFF_BIT] <= cpu_clock_off_ff;
               prdata_ff[`BCGOC_STAT_WAKE_BIT]   <= wake_any;
               prdata_ff[`BCGOC_STAT_OSCON_BIT]  <= osc_ctl.osc_power_on;
               prdata_ff[`BCGOC_STAT_TREE_BIT]   <= osc_ctl.tree_gate_enable;
            end
            `BCGOC_OFS_WAKE_EN:   prdata_ff[NSRC-1:0] <= group_irq_enable_ff;
            `BCGOC_OFS_WAKE_EDGE: prdata_ff[NSRC-1:0] <= wake_edge_ff;
            default:              prdata_ff <= '0;
         endcase
      end
      else
      begin
         pslverr_ff <= 1'b0;
      end
   end

   // ==========================================================
   // Per-block clocking state machines
   assign block_sleep_request = sleep_en_ff & {NBLK{sleep_flag_ff}};

   always_comb
   begin
      for (int i = 0; i < NBLK; i++)
      begin
         nxt_st[i] = st_ff[i];
         unique case (st_ff[i])
            bcgoc_pkg::BCGOC_SLEEP:
            begin
               // Leave only toward FULL POWER, never straight to DISABLED
               if (!block_sleep_request[i])
                  nxt_st[i] = bcgoc_pkg::BCGOC_FULL;
            end
            default:
            begin
               if (!blk_en_ff[i])
                  nxt_st[i] = bcgoc_pkg::BCGOC_DISABLED;
               else if (!block_sleep_request[i])
                  nxt_st[i] = bcgoc_pkg::BCGOC_FULL;
               else if (!block_idle[i])
                  nxt_st[i] = bcgoc_pkg::BCGOC_PREP;
               else
                  nxt_st[i] = bcgoc_pkg::BCGOC_SLEEP;
            end
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      for (int i = 0; i < NBLK; i++)
      begin
         if (rst)
            st_ff[i] <= bcgoc_pkg::BCGOC_DISABLED;
         else
            st_ff[i] <= nxt_st[i];
      end
   end

   always_comb
   begin
      for (int i = 0; i < NBLK; i++)
      begin
         clk_req[i]     = clk_needed(st_ff[i]);
         sleeping[i]    = (st_ff[i] == bcgoc_pkg::BCGOC_SLEEP);
         block_reset[i] = (st_ff[i] == bcgoc_pkg::BCGOC_DISABLED);
      end
   end

   // Gate enable from a flop so it never glitches into the gating cell
   always_ff @(posedge clock)
   begin
      if (rst)
         gate_en_ff <= '0;
      else
         gate_en_ff <= clk_req;
   end

   assign block_clock_request = clk_req;
   assign block_clock_gate_en = gate_en_ff;

   // ==========================================================
   // Wake sources: three-stage sync, change once stages 2 and 3 agree
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         sync3_ff <= '0;
         src_ff   <= '0;
      end
      else
      begin
         sync1_ff <= wake_source;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         src_ff   <= (sync2_ff & ~(sync2_ff ^ sync3_ff)) | (src_ff & (sync2_ff ^ sync3_ff));
      end
   end

   // Only enabled, edge-configured sources wake; level ones only interrupt
   always_comb
   begin
      for (int i = 0; i < NSRC; i++)
      begin
         wake_trig[i] = group_irq_enable_ff[i] && wake_edge_ff[i]
                      && sync2_ff[i] && sync3_ff[i] && !src_ff[i];
         level_irq[i] = group_irq_enable_ff[i] && !wake_edge_ff[i] && src_ff[i];
      end
   end

   always_ff @(posedge clock)
   begin
      for (int i = 0; i < NSRC; i++)
      begin
         if (rst)
            wake_cnt_ff[i] <= '0;
         else if (wake_trig[i])
            wake_cnt_ff[i] <= WAKE_LEN_VEC[i*8 +: 8];
         else if (wake_cnt_ff[i] != 8'h00)
            wake_cnt_ff[i] <= wake_cnt_ff[i] - 8'h01;
      end
   end

   always_comb
   begin
      wake_any = 1'b0;
      for (int i = 0; i < NSRC; i++)
      begin
         wake_any = wake_any || (wake_cnt_ff[i] != 8'h00);
      end
   end

   assign wake_active = wake_any;

   // ==========================================================
   // Processor interrupt and clock-off indication
   always_ff @(posedge clock)
   begin
      if (rst)
         cpu_irq_ff <= 1'b0;
      else
         cpu_irq_ff <= (|wake_trig) || (|level_irq);
   end

   // An interrupt wins over a same-cycle sleep entry
   always_ff @(posedge clock)
   begin
      if (rst)
         cpu_clock_off_ff <= 1'b0;
      else if (cpu_irq_ff)
         cpu_clock_off_ff <= 1'b0;
      else if (cpu_sleep_enter)
         cpu_clock_off_ff <= 1'b1;
   end

   assign cpu_irq       = cpu_irq_ff;
   assign cpu_clock_off = cpu_clock_off_ff;

   // ==========================================================
   // Ring oscillator control
   assign allowed  = !(|clk_req) && cpu_clock_off_ff;
   assign run_calc = !allowed || wake_any;

   always_comb
   begin
      osc_ctl.osc_sleep_allowed = allowed;
      osc_ctl.osc_run_enable    = 1'b1;
      osc_ctl.osc_power_on      = 1'b1;
      osc_ctl.tree_gate_enable  = 1'b1;
      unique case (mode_ff)
         `BCGOC_MODE_OFF:
         begin
            osc_ctl.osc_run_enable   = 1'b0;
            osc_ctl.osc_power_on     = 1'b0;
            osc_ctl.tree_gate_enable = 1'b0;
         end
         `BCGOC_MODE_SLEEP:
         begin
            osc_ctl.osc_run_enable   = run_calc;
            osc_ctl.osc_power_on     = run_calc;
            osc_ctl.tree_gate_enable = run_calc;
         end
         `BCGOC_MODE_GATE:
         begin
            osc_ctl.osc_run_enable   = run_calc;
            osc_ctl.tree_gate_enable = run_calc;
         end
         `BCGOC_MODE_ON:
         begin
            osc_ctl.osc_run_enable = 1'b1;
         end
      endcase
   end

endmodule : bcgoc_top

// ### rtl/bcgoc_params.svh
// Constants for block clock gating and ring oscillator control
`ifndef BCGOC_PARAMS_SVH
`define BCGOC_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define BCGOC_OFS_CLK_CTRL     8'h00
`define BCGOC_OFS_SLEEP_EN     8'h04
`define BCGOC_OFS_BLK_EN       8'h08
`define BCGOC_OFS_CLK_REQ      8'h0C
`define BCGOC_OFS_OSC_STAT     8'h10
`define BCGOC_OFS_WAKE_EN      8'h14
`define BCGOC_OFS_WAKE_EDGE    8'h18

// ==========================================================
// Clock control fields and reset values
`define BCGOC_MODE_LSB         0
`define BCGOC_MODE_MSB         1
`define BCGOC_SLEEP_FLAG_BIT   2
`define BCGOC_MODE_RST         2'h1
`define BCGOC_MODE_OFF         2'h0
`define BCGOC_MODE_SLEEP       2'h1
`define BCGOC_MODE_GATE        2'h2
`define BCGOC_MODE_ON          2'h3

// ==========================================================
// Oscillator status fields
`define BCGOC_STAT_RUN_BIT     0
`define BCGOC_STAT_ALLOW_BIT   1
`define BCGOC_STAT_CPUOFF_BIT  2
`define BCGOC_STAT_WAKE_BIT    3
`define BCGOC_STAT_OSCON_BIT   4
`define BCGOC_STAT_TREE_BIT    5

// ==========================================================
// Wake pulse length in cycles, per source
`define BCGOC_WAKE_LEN_DEF     8'h04

`endif

// ### rtl/bcgoc_pkg.sv
// Types shared by the block clock gating and oscillator control logic
package bcgoc_pkg;

   // ==========================================================
   // Per-block clocking state, one-hot
   typedef enum logic [3:0] {
      BCGOC_DISABLED = 4'h1,
      BCGOC_FULL     = 4'h2,
      BCGOC_PREP     = 4'h4,
      BCGOC_SLEEP    = 4'h8
   } bcgoc_state_e;

   // ==========================================================
   // Oscillator control outputs
   typedef struct packed {
      logic osc_run_enable;
      logic osc_sleep_allowed;
      logic osc_power_on;
      logic tree_gate_enable;
   } bcgoc_osc_s;

endpackage : bcgoc_pkg

// ### tb/bcgoc_monitor.sv
// Checker of the clock gating and oscillator control ports
module bcgoc_monitor #(
   parameter int NBLK = 32,
   parameter int NSRC = 8
) (
   // Clock and reset
   input wire logic                  clock,
   input wire logic                  rst,
   // Blocks
   input wire logic [NBLK-1:0]       block_idle,
   input wire logic [NBLK-1:0]       block_sleep_request,
   input wire logic [NBLK-1:0]       block_clock_request,
   input wire logic [NBLK-1:0]       block_clock_gate_en,
   input wire logic [NBLK-1:0]       block_reset,
   // Processor, wake and oscillator
   input wire logic                  cpu_sleep_enter,
   input wire logic                  cpu_clock_off,
   input wire logic                  cpu_irq,
   input wire logic                  wake_active,
   input wire bcgoc_pkg::bcgoc_osc_s osc_ctl
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [NBLK-1:0] asleep;

   // SLEEPING shows as neither requesting nor held in reset
   assign asleep = ~block_clock_request & ~block_reset;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   // ==========================================================
   // Block states
   chk_dis_noreq: assert property ((block_reset & block_clock_request) == '0)
      else $error("clock request while disabled");
   chk_busy_keep: assert property (
      block_clock_request[0] && block_sleep_request[0] && !block_idle[0]
      |=> block_clock_request[0])
      else $error("busy block dropped its request");
   chk_idle_sleep: assert property (
      block_sleep_request[0] && block_idle[0] && !block_reset[0] |=> !block_clock_request[0])
      else $error("idle block kept its request");
   chk_no_sleep_dis: assert property (1'b1 |=> (block_reset & $past(asleep)) == '0)
      else $error("sleeping block went straight to disabled");
   chk_gate_delay: assert property (
      1'b1 |=> block_clock_gate_en == $past(block_clock_request))
      else $error("gate enable not a delayed request");

   // ==========================================================
   // Oscillator
   chk_allow_calc: assert property (
      osc_ctl.osc_sleep_allowed == (block_clock_request == '0 && cpu_clock_off))
      else $error("sleep allowed wrong");
   chk_osc_keep: assert property (
      (!osc_ctl.osc_sleep_allowed || wake_active) && osc_ctl.osc_power_on
      |-> osc_ctl.osc_run_enable)
      else $error("run enable low while needed");
   chk_tree_run: assert property (osc_ctl.tree_gate_enable == osc_ctl.osc_run_enable)
      else $error("tree gate differs from run enable");
   chk_run_power: assert property (osc_ctl.osc_run_enable |-> osc_ctl.osc_power_on)
      else $error("run enable without power");

   // ==========================================================
   // Processor and wake
   chk_cpu_off: assert property ($rose(cpu_clock_off) |-> $past(cpu_sleep_enter))
      else $error("clock off without sleep entry");
   chk_wake_flag: assert property (
      $rose(wake_active) |-> block_sleep_request == '0 && cpu_irq ##1 !cpu_clock_off)
      else $error("wake did not clear flag or raise interrupt");
   chk_wake_len: assert property (
      $rose(wake_active) |-> wake_active [*4] ##1 !wake_active)
      else $error("wake pulse length wrong");
endmodule : bcgoc_monitor

bind bcgoc_top bcgoc_monitor #(.NBLK(NBLK), .NSRC(NSRC)) u_mon (
   .clock(clock), .rst(rst), .block_idle(block_idle),
   .block_sleep_request(block_sleep_request), .block_clock_request(block_clock_request),
   .block_clock_gate_en(block_clock_gate_en), .block_reset(block_reset),
   .cpu_sleep_enter(cpu_sleep_enter), .cpu_clock_off(cpu_clock_off), .cpu_irq(cpu_irq),
   .wake_active(wake_active), .osc_ctl(osc_ctl)
);

// ### tb/bcgoc_peer.sv
// Behavioural model of the peripheral blocks and the processor
module bcgoc_peer #(
   parameter int NBLK = 4
) (
   // Clock and reset
   input  wire logic            clock,
   input  wire logic            rst,
   // Bench commands
   input  wire logic [NBLK-1:0] busy_cmd,
   input  wire logic            sleep_cmd,
   // Device side
   input  wire logic            cpu_clock_off,
   output logic      [NBLK-1:0] block_idle,
   output logic                 cpu_sleep_enter
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [NBLK-1:0] idle_ff;
   logic            enter_ff;

   assign block_idle = idle_ff;
   assign cpu_sleep_enter = enter_ff;

   // Idle lags the work by a cycle, as a real shifter finishing would
   always_ff @(posedge clock)
   begin
      if (rst)
         idle_ff <= '1;
      else
         idle_ff <= ~busy_cmd;
   end

   // Only an awake processor can execute its sleep instruction
   always_ff @(posedge clock)
   begin
      if (rst)
         enter_ff <= 1'b0;
      else
         enter_ff <= sleep_cmd && !cpu_clock_off;
   end
endmodule : bcgoc_peer

// ### tb/tb_block_clock_gating_osc_control.sv
// Self-checking bench of the clock gating and oscillator control block
`include "bcgoc_params.svh"

module tb_block_clock_gating_osc_control;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int NB = 4;
   localparam int NS = 2;

   logic clock, rst, psel, penable, pwrite, pready, pslverr;
   logic cpu_sleep_enter, cpu_clock_off, cpu_irq, wake_active, sleep_cmd, err, hit;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [NB-1:0] block_idle, block_sleep_request, block_clock_request;
   logic [NB-1:0] block_clock_gate_en, block_reset, busy_cmd;
   logic [NS-1:0] wake_source;
   bcgoc_pkg::bcgoc_osc_s osc_ctl;
   int num_errors, n_tests, cyc;

   bcgoc_top #(.NBLK(NB), .NSRC(NS)) DUT (
      .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .block_idle(block_idle), .block_sleep_request(block_sleep_request),
      .block_clock_request(block_clock_request), .block_clock_gate_en(block_clock_gate_en),
      .block_reset(block_reset), .cpu_sleep_enter(cpu_sleep_enter),
      .cpu_clock_off(cpu_clock_off), .cpu_irq(cpu_irq), .wake_source(wake_source),
      .wake_active(wake_active), .osc_ctl(osc_ctl)
   );

   bcgoc_peer #(.NBLK(NB)) u_peer (
      .clock(clock), .rst(rst), .busy_cmd(busy_cmd), .sleep_cmd(sleep_cmd),
      .cpu_clock_off(cpu_clock_off), .block_idle(block_idle),
      .cpu_sleep_enter(cpu_sleep_enter)
   );

   always #20 clock = ~clock;

   // ==========================================================
   // Helpers
   task finish_test;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task tick(input int n);
      repeat (n) @(posedge clock);
   endtask : tick

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1)
         @(posedge clock);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wait_wake;
      hit = 1'b0;
      repeat (12)
      begin
         @(posedge clock);
         // A wake counts only if one of its cycles also has the oscillator on
         if (wake_active === 1'b1 && osc_ctl.osc_run_enable === 1'b1)
            hit = 1'b1;
      end
   endtask : wait_wake

   // ==========================================================
   // Scenarios
   task t_reset;
      apb(1'b0, `BCGOC_OFS_CLK_CTRL, 32'h0);
      chk(rd, 32'h1);
      chk(32'(block_reset), 32'hF);
      chk(32'(osc_ctl.osc_run_enable), 32'h1);
      apb(1'b0, 8'h1C, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
   endtask : t_reset

   task t_blocks;
      busy_cmd <= 4'h1;
      apb(1'b1, `BCGOC_OFS_BLK_EN, 32'hF);
      tick(3);
      chk(32'(block_clock_request), 32'hF);
      apb(1'b1, `BCGOC_OFS_SLEEP_EN, 32'h3);
      apb(1'b1, `BCGOC_OFS_CLK_CTRL, 32'h5);
      tick(3);
      chk(32'(block_sleep_request), 32'h3);
      chk(32'(block_clock_request), 32'hD);
      busy_cmd <= 4'h0;
      tick(4);
      chk(32'(block_clock_request), 32'hC);
      chk(32'(block_clock_gate_en), 32'hC);
      chk(32'(osc_ctl.osc_run_enable), 32'h1);
      apb(1'b1, `BCGOC_OFS_BLK_EN, 32'h0);
      tick(3);
      chk(32'(block_reset), 32'hC);
      apb(1'b0, `BCGOC_OFS_BLK_EN, 32'h0);
      chk(rd, 32'h3);
      apb(1'b0, `BCGOC_OFS_CLK_REQ, 32'h0);
      chk(rd, 32'h0);
      chk(32'(osc_ctl.osc_run_enable), 32'h1);
   endtask : t_blocks

   task t_osc;
      sleep_cmd <= 1'b1;
      @(posedge clock);
      sleep_cmd <= 1'b0;
      tick(3);
      chk(32'(cpu_clock_off), 32'h1);
      chk(32'(osc_ctl.osc_sleep_allowed), 32'h1);
      for (int m = 0; m < 4; m++)
      begin
         apb(1'b1, `BCGOC_OFS_CLK_CTRL, 32'(4 + m));
         tick(2);
         chk(32'(osc_ctl.osc_run_enable), 32'(m == 3));
         chk(32'(osc_ctl.osc_power_on), 32'(m >= 2));
         chk(32'(osc_ctl.tree_gate_enable), 32'(m == 3));
      end
      apb(1'b1, `BCGOC_OFS_CLK_CTRL, 32'h5);
      apb(1'b0, `BCGOC_OFS_OSC_STAT, 32'h0);
      chk(rd, (32'h1 << `BCGOC_STAT_ALLOW_BIT) | (32'h1 << `BCGOC_STAT_CPUOFF_BIT));
   endtask : t_osc

   task t_wake;
      apb(1'b1, `BCGOC_OFS_WAKE_EN, 32'h1);
      wake_source <= 2'b01;
      wait_wake();
      chk({31'h0, hit}, 32'h1);
      tick(4);
      chk(32'(wake_active), 32'h0);
      chk(32'(cpu_clock_off), 32'h0);
      chk(32'(block_clock_request), 32'h3);
      apb(1'b0, `BCGOC_OFS_CLK_CTRL, 32'h0);
      chk(rd, 32'h1);
      wake_source <= 2'b00;
      apb(1'b1, `BCGOC_OFS_WAKE_EDGE, 32'h1);
      apb(1'b1, `BCGOC_OFS_WAKE_EN, 32'h3);
      wake_source <= 2'b10;
      wait_wake();
      chk({31'h0, hit}, 32'h0);
      chk(32'(cpu_irq), 32'h1);
      wake_source <= 2'b00;
   endtask : t_wake

   // ==========================================================
   // Watchdog on the whole run
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: run timed out", $time);
         finish_test();
      end
   end

   initial
   begin
      clock = 1'b0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      busy_cmd = 4'h0;
      sleep_cmd = 1'b0;
      wake_source = 2'b00;
      num_errors = 0;
      n_tests = 0;
      cyc = 0;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      t_reset();
      t_blocks();
      t_osc();
      t_wake();
      finish_test();
   end
endmodule : tb_block_clock_gating_osc_control
